// *** bench/ahb_host.sv ***
// Purpose: Host that polls the alarm registers and watches the pin.
// Assumes: One slave; hready is its hreadyout.
// Notes: Only single whole-word transfers.
`timescale 1ns/1ps
module ahb_host (
    // Clock, answer and pin.
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic alert,
    // Request.
    output logic hsel = 1'b0,
    output logic [31:0] haddr = 32'h0,
    output logic [1:0] htrans = 2'b00,
    output logic hwrite = 1'b0,
    output logic [2:0] hsize = 3'b010,
    output logic [31:0] hwdata = 32'h0
);
    task automatic xfer(input logic w, input logic [31:0] a, wd,
            output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    // Members go first, or they would set the block bits again.
    task automatic clear_all;
        logic [31:0] x;
        xfer(1'b1, 32'hc, 32'h3fffff, x);
        xfer(1'b1, 32'h18, 32'h1ff, x);
    endtask
    // The pin is polled as a level, since it may lag the clears.
    task automatic wait_low(output int n);
        n = 0;
        while (alert !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask
endmodule

// *** bench/alarm_monitor.sv ***
// Purpose: Port checks for the alarm sticky aggregator.
// Assumes: Zero wait states, single word transfers.
// Notes: Live reads are judged only after the inputs have settled.
`timescale 1ns/1ps
module alarm_monitor (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Bus.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Alarms and pins.
    input wire logic [11:0] REF_MON_ALARM,
    input wire logic [19:0] LOOP_STATE,
    input wire logic APLL_LOCKED,
    input wire logic [3:0] GPIO_OUT,
    input wire logic [3:0] GPIO_OE
);
    logic rd, rq, wt, cl;
    logic [31:0] aq, sk;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    assign rd = HSEL && HTRANS[1] && HREADY && !HWRITE;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rq <= 1'b0;
            wt <= 1'b0;
            cl <= 1'b0;
            aq <= 32'h0;
            sk <= 32'h0;
        end else begin
            rq <= rd;
            wt <= HSEL && HTRANS[1] && HREADY && HWRITE;
            aq <= HADDR;
            if (rq && aq == 32'h8) begin
                sk <= HRDATA;
                cl <= 1'b0;
            end else if (wt && aq == 32'hc) begin
                cl <= 1'b1;
            end
        end
    end
    function automatic logic [9:0] loops(input logic [19:0] s, input logic a);
        for (int p = 0; p < 5; p++) begin
            loops[2*p] = s[4*p+:4] == 4'h4;
            loops[2*p+1] = s[4*p+:4] == 4'h3 && a;
        end
    endfunction
    sequence s_calm;
        ($stable(REF_MON_ALARM) && $stable(LOOP_STATE)
            && $stable(APLL_LOCKED))[*4];
    endsequence
    property p_live_ref;
        s_calm ##0 (rd && HADDR == 32'h4) |=>
            HRDATA[11:0] == $past(REF_MON_ALARM);
    endproperty
    a_live_ref: assert property (p_live_ref)
        else $error("live monitor bits wrong");
    property p_live_loop;
        s_calm ##0 (rd && HADDR == 32'h4) |=> HRDATA[31:12] ==
            {10'h0, loops($past(LOOP_STATE), $past(APLL_LOCKED))};
    endproperty
    a_live_loop: assert property (p_live_loop)
        else $error("live loop bits wrong");
    property p_state;
        s_calm ##0 (rd && HADDR == 32'h1c) |=>
            HRDATA == {12'h0, $past(LOOP_STATE)};
    endproperty
    a_state: assert property (p_state)
        else $error("loop state read wrong");
    property p_wo_zero;
        rd && (HADDR == 32'hc || HADDR == 32'h18 || HADDR >= 32'h30)
            |=> HRDATA == 32'h0;
    endproperty
    a_wo_zero: assert property (p_wo_zero)
        else $error("clear or hole read not zero");
    property p_off_pin;
        (GPIO_OUT & ~GPIO_OE) == 4'h0;
    endproperty
    a_off_pin: assert property (p_off_pin)
        else $error("disabled pin driven high");
    property p_oe_cause;
        $changed(GPIO_OE) |-> $past(wt, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("pin enable moved without a write");
    property p_okay;
        HREADYOUT && !HRESP;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready okay");
    // Without a clear in between, no sticky bit may vanish.
    property p_keep;
        rq && aq == 32'h8 && !cl |-> (HRDATA & sk) == sk;
    endproperty
    a_keep: assert property (p_keep)
        else $error("sticky bit dropped by itself");
endmodule
bind alarm_sticky_aggregator alarm_monitor i_mon (.REF_CLK, .RST_N,
    .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT,
    .HRESP, .REF_MON_ALARM, .LOOP_STATE, .APLL_LOCKED, .GPIO_OUT,
    .GPIO_OE);

// *** bench/alarm_sticky_aggregator_bench.sv ***
// Purpose: Register level tests of the alarm sticky aggregator.
// Assumes: Alert hold shortened to 8 cycles.
// Notes: Stickies are cleared between scenarios.
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_sticky_aggregator_bench;
    import alarm_pkg::*;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [11:0] mon = 12'h0;
    logic [19:0] lst = 20'h0;
    logic apll = 1'b0;
    logic hsel, hwrite, hrdy;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0] gout, goe;
    int failures = 0;
    int total_checks = 0;
    int n;
    always #2 REF_CLK = ~REF_CLK;
    alarm_sticky_aggregator #(.HOLD_CYC(8)) i_dut (.REF_CLK(REF_CLK),
        .RST_N(RST_N), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(), .REF_MON_ALARM(mon),
        .LOOP_STATE(lst), .APLL_LOCKED(apll), .GPIO_OUT(gout),
        .GPIO_OE(goe));
    ahb_host i_host (.clk(REF_CLK), .hready(hrdy), .hrdata(hrdata),
        .alert(gout[2]), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, v);
        logic [31:0] x;
        i_host.xfer(1'b1, a, v, x);
    endtask
    task automatic rd(input string nm, input logic [31:0] a, e);
        logic [31:0] x;
        i_host.xfer(1'b0, a, 32'h0, x);
        chk(nm, x, e);
    endtask
    task cyc(input int c);
        repeat (c) @(posedge REF_CLK);
    endtask
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    initial begin
        cyc(10);
        RST_N <= 1'b1;
        chk("oe", goe, 4'h0);
        rd("ctrl", `OFS_CTRL, 32'h1);
        rd("cfg", `OFS_GPIO_CFG0, 32'h0);
        rd("clr", `OFS_STICKY_CLR, 32'h0);
        rd("hole", 32'h40, 32'h0);
        wr(32'h100, 32'h0);
        rd("alias", `OFS_CTRL, 32'h1);
        wr(`OFS_LIVE, 32'hffffffff);
        rd("ro", `OFS_LIVE, 32'h0);
        mon <= 12'h0a5;
        cyc(6);
        rd("live", `OFS_LIVE, 32'h0a5);
        rd("rise", `OFS_STICKY, 32'h0a5);
        rd("blk", `OFS_BLK_STICKY, 32'h7);
        wr(`OFS_STICKY_CLR, 32'h3fffff);
        rd("clrall", `OFS_STICKY, 32'h0);
        mon <= 12'h0;
        cyc(6);
        rd("fall", `OFS_STICKY, 32'h0a5);
        rd("self", `OFS_LIVE, 32'h0);
        wr(`OFS_STICKY_CLR, 32'h1);
        rd("one", `OFS_STICKY, 32'h0a4);
        i_host.clear_all();
        rd("blk0", `OFS_BLK_STICKY, 32'h0);
        lst <= 20'h40034;
        apll <= 1'b1;
        cyc(6);
        rd("loops", `OFS_LIVE, 32'h109000);
        rd("state", `OFS_LOOP_STATE, 32'h40034);
        rd("entry", `OFS_STICKY, 32'h109000);
        apll <= 1'b0;
        cyc(6);
        rd("unlock", `OFS_LIVE, 32'h101000);
        rd("keep", `OFS_STICKY, 32'h109000);
        lst <= 20'h0;
        cyc(6);
        i_host.clear_all();
        wr(`OFS_CTRL, 32'h0);
        mon <= 12'h002;
        cyc(6);
        rd("gated", `OFS_STICKY, 32'h0);
        rd("live2", `OFS_LIVE, 32'h2);
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_GPIO_CFG0, 32'h101);
        cyc(3);
        chk("livepin", gout, 4'h1);
        chk("pinoe", goe, 4'h1);
        wr(`OFS_GPIO_CFG0, 32'h141);
        wr(`OFS_GPIO_CFG0 + 32'h4, 32'h121);
        cyc(3);
        chk("inv", gout, 4'h0);
        mon <= 12'h0;
        cyc(8);
        chk("stickypin", gout, 4'h3);
        wr(`OFS_ALERT_EN, 32'h2);
        rd("alen", `OFS_ALERT_EN, 32'h2);
        wr(`OFS_GPIO_CFG0 + 32'h8, 32'h180);
        cyc(4);
        chk("alert", gout[2], 1'b1);
        wr(`OFS_BLK_CLR, 32'h1ff);
        rd("rearm", `OFS_BLK_STICKY, 32'h1);
        wr(`OFS_STICKY_CLR, 32'h2);
        cyc(20);
        chk("blkhold", gout[2], 1'b1);
        wr(`OFS_BLK_CLR, 32'h1);
        i_host.wait_low(n);
        chk("release", n >= 8 && n <= 20, 1'b1);
        mon <= 12'h008;
        cyc(12);
        chk("masked", gout[2], 1'b0);
        wr(`OFS_GPIO_CFG0 + 32'h8, 32'h1c0);
        cyc(3);
        chk("alertinv", gout[2], 1'b1);
        wr(`OFS_GPIO_CFG0 + 32'hc, 32'h11f);
        cyc(3);
        chk("nosrc", gout[3], 1'b0);
        wr(`OFS_GPIO_CFG0 + 32'hc, 32'h15f);
        cyc(3);
        chk("nosrcinv", gout[3], 1'b1);
        tally_and_finish();
    end
endmodule

// *** verilog/alarm_pkg.sv ***
// Purpose: Types shared by the alarm sticky aggregator modules.
// Assumes: Sizes come from alarm_regs.svh.
// Notes:   No logic here.
`include "alarm_regs.svh"

package alarm_pkg;

    typedef struct packed {
        logic en;
        logic alert;
        logic inv;
        logic sticky_mode;
        logic [`SRC_W-1:0] src;
    } gpio_cfg_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WRITE = 2'b10
    } bus_phase_t;

    typedef struct packed {
        logic [`NUM_ALM-1:0] live;
        logic [`NUM_ALM-1:0] sticky;
    } alarm_vec_t;

    typedef struct packed {
        bus_phase_t ph;
        logic [7:0] waddr;
        logic glb_en;
        logic [`NUM_ALM-1:0] alert_en;
        logic [`NUM_BLK-1:0] blk_sticky;
        gpio_cfg_t [`NUM_GPIO-1:0] gcfg;
        logic [`NUM_ALM-1:0] clr;
        logic [`NUM_BLK-1:0] bclr;
        logic [31:0] rdata;
        logic [`NUM_GPIO-1:0] gout;
        logic [`NUM_GPIO-1:0] goe;
        logic [`NUM_LOOP*`STATE_W-1:0] lstate;
        logic [1:0] apll_sync;
    } core_state_t;

endpackage

// *** verilog/alarm_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts for
//          the alarm sticky aggregator.
// Assumes: 32-bit AHB-Lite data, one register per aligned word.
// Notes:   Definitions only.
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH

// Source population.
`define NUM_REF 4
`define NUM_LOOP 5
`define ALM_PER_REF 3
`define ALM_PER_LOOP 2
`define NUM_ALM 22
`define NUM_BLK 9
`define NUM_GPIO 4
`define STATE_W 4
`define SRC_W 5

// Alarm positions inside one reference monitor group.
`define ALM_FREQ 0
`define ALM_SIGNAL_LOSS 1
`define ALM_ACTIVITY 2
// Alarm positions inside one loop group.
`define ALM_HOLDOVER 0
`define ALM_LOCKED 1

// Loop state codes seen on the state bus.
`define LOOP_ST_LOCKED 4'h3
`define LOOP_ST_HOLDOVER 4'h4

// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_LIVE 8'h04
`define OFS_STICKY 8'h08
`define OFS_STICKY_CLR 8'h0c
`define OFS_ALERT_EN 8'h10
`define OFS_BLK_STICKY 8'h14
`define OFS_BLK_CLR 8'h18
`define OFS_LOOP_STATE 8'h1c
`define OFS_GPIO_CFG0 8'h20
`define GPIO_CFG_W 9

// Control fields and reset values.
`define CTRL_GLOBAL_EN_BIT 0
`define GLOBAL_EN_RESET 1'b1
`define ALERT_EN_RESET 22'h000000
`define GPIO_CFG_RESET 9'h000

// Alert pin release window.
`define ALERT_HOLD_NS 200000
`define REF_CLK_MHZ 250
`define ALERT_HOLD_CYC (`ALERT_HOLD_NS * `REF_CLK_MHZ / 1000)
`define HOLD_W 16

`endif

// *** verilog/alarm_sticky_aggregator.sv ***
// Purpose: Live and sticky alarm status, per-alarm GPIO outputs and one
//          aggregated alert, reached over AHB-Lite.
// Assumes: Loop state bus is on REF_CLK; monitor alarms may be async.
// Notes:   Zero wait states; every transfer answers OKAY.
//
// Overview of operation
// - Live bit shows current alarm state.
// - Sticky sets on change, holds until cleared.
// - Both rising and falling edges set sticky.
// - Sticky never self-clears; live does.
// - Assigned GPIO shows live or sticky alarm.
// - Per-GPIO inversion flips driven alarm level.
// - Alert ORs enabled sticky bits only.
// - Host picks alert GPIO, sources, polarity.
// - Global enable gates sticky capture only; live bits stay ungated.
// - Every alarm has live, sticky, clear, control.
// - Clear any single bit or any combination.
// - Block sticky too; alert needs both cleared.
// - Alert pin may linger 200us after clearing.
// - Holdover live follows loop holdover state.
// - Locked live needs loop and analog lock.
// - Loop stickies on state entry; state readable.
// - Monitors give frequency, loss, activity alarms.
// - Alert holds until contributors all cleared.
`timescale 1ns/1ps
`include "alarm_regs.svh"

module alarm_sticky_aggregator #(
    parameter int unsigned HOLD_CYC = `ALERT_HOLD_CYC
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RST_N,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Alarm sources.
    input wire logic [`NUM_REF*`ALM_PER_REF-1:0] REF_MON_ALARM,
    input wire logic [`NUM_LOOP*`STATE_W-1:0] LOOP_STATE,
    input wire logic APLL_LOCKED,
    // Alarm pins.
    output logic [`NUM_GPIO-1:0] GPIO_OUT,
    output logic [`NUM_GPIO-1:0] GPIO_OE
);
    import alarm_pkg::*;

    localparam int REF_BITS = `NUM_REF * `ALM_PER_REF;

    core_state_t st_r;
    core_state_t st_nxt;
    alarm_vec_t alm;
    logic [`NUM_ALM-1:0] live_raw;
    logic [`NUM_BLK-1:0] blk_any;
    logic [`NUM_BLK-1:0] blk_en;
    logic alert_req;
    logic alert_pin;
    logic take;
    logic addr_ok;
    logic [`NUM_GPIO-1:0] rd_hit;
    logic [`NUM_GPIO-1:0] wr_hit;
    logic [`NUM_GPIO-1:0] pin_lvl;
    logic [`NUM_GPIO-1:0] pin_oe;
    gpio_cfg_t [`NUM_GPIO-1:0] cfg_nxt;

    // Monitor alarms enter as they are; their meaning is the monitor's.
    assign live_raw[REF_BITS-1:0] = REF_MON_ALARM;

    // Per-block status and per-loop live decoding.
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_REF; gi++) begin : g_ref
            assign blk_any[gi] =
                |alm.sticky[gi*`ALM_PER_REF +: `ALM_PER_REF];
            assign blk_en[gi] =
                |st_r.alert_en[gi*`ALM_PER_REF +: `ALM_PER_REF];
        end
        for (gi = 0; gi < `NUM_LOOP; gi++) begin : g_loop
            localparam int B = REF_BITS + gi * `ALM_PER_LOOP;
            logic [`STATE_W-1:0] lst;
            assign lst = LOOP_STATE[gi*`STATE_W +: `STATE_W];
            // Entry into a state raises the sticky via the edge logic.
            assign live_raw[B + `ALM_HOLDOVER] =
                (lst == `LOOP_ST_HOLDOVER);
            assign live_raw[B + `ALM_LOCKED] =
                (lst == `LOOP_ST_LOCKED) & st_r.apll_sync[1];
            assign blk_any[`NUM_REF + gi] =
                |alm.sticky[B +: `ALM_PER_LOOP];
            assign blk_en[`NUM_REF + gi] =
                |st_r.alert_en[B +: `ALM_PER_LOOP];
        end
    endgenerate

    // One sticky bit and one clear bit per alarm.
    sticky_bank #(
        .W(`NUM_ALM)
    ) u_bank (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .live_async(live_raw),
        .arm(st_r.glb_en),
        .clr(st_r.clr),
        .stat(alm)
    );

    // Block stickies keep the alert up until they too are cleared.
    assign alert_req = |(alm.sticky & st_r.alert_en) |
        |(st_r.blk_sticky & blk_en);

    // The stretch spares a host that polls from seeing a flicker.
    alert_hold #(
        .HOLD(HOLD_CYC)
    ) u_hold (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .req(alert_req),
        .hold(alert_pin)
    );

    // Per-pin level and address match; each pin decodes its own settings.
    generate
        for (gi = 0; gi < `NUM_GPIO; gi++) begin : g_pin
            gpio_cfg_t cfg;
            logic [`NUM_ALM-1:0] pick_vec;
            logic pick;
            assign cfg = st_r.gcfg[gi];
            assign rd_hit[gi] =
                (HADDR[7:0] == 8'(`OFS_GPIO_CFG0 + 4 * gi));
            assign wr_hit[gi] =
                (st_r.waddr == 8'(`OFS_GPIO_CFG0 + 4 * gi));
            assign cfg_nxt[gi] = wr_hit[gi] ?
                gpio_cfg_t'(HWDATA[`GPIO_CFG_W-1:0]) : cfg;
            assign pick_vec = cfg.sticky_mode ? alm.sticky : alm.live;
            always_comb begin
                if (cfg.alert) begin
                    pick = alert_pin;
                end else if (cfg.src < `SRC_W'(`NUM_ALM)) begin
                    pick = pick_vec[cfg.src];
                end else begin
                    pick = 1'b0;
                end
            end
            // A disabled pin is released and drives low.
            assign pin_lvl[gi] = cfg.en & (pick ^ cfg.inv);
            assign pin_oe[gi] = cfg.en;
        end
    endgenerate

    assign take = HSEL & HTRANS[1] & HREADY;
    // Addresses above the map are ignored rather than aliased onto it, so
    // a stray access cannot reach a register through its low byte.
    assign addr_ok = (HADDR[31:8] == 24'h000000);

    always_comb begin
        st_nxt = st_r;
        st_nxt.clr = '0;
        st_nxt.bclr = '0;
        st_nxt.lstate = LOOP_STATE;
        // The analog lock pin is asynchronous; two stages before any use.
        st_nxt.apll_sync = {st_r.apll_sync[0], APLL_LOCKED};

        // A block bit is re-set while any of its alarms stays sticky.
        st_nxt.blk_sticky = (st_r.blk_sticky & ~st_r.bclr) |
            blk_any;

        // Address phase: latch the write target, or fetch read data.
        st_nxt.ph = (take & HWRITE & addr_ok) ? BUS_WRITE : BUS_IDLE;
        if (take) begin
            st_nxt.waddr = HADDR[7:0];
        end
        if (take & ~HWRITE) begin
            st_nxt.rdata = '0;
            if (addr_ok) begin
                case (HADDR[7:0])
                    `OFS_CTRL: begin
                        st_nxt.rdata[`CTRL_GLOBAL_EN_BIT] = st_r.glb_en;
                    end
                    `OFS_LIVE: begin
                        st_nxt.rdata[`NUM_ALM-1:0] = alm.live;
                    end
                    `OFS_STICKY: begin
                        st_nxt.rdata[`NUM_ALM-1:0] = alm.sticky;
                    end
                    `OFS_ALERT_EN: begin
                        st_nxt.rdata[`NUM_ALM-1:0] = st_r.alert_en;
                    end
                    `OFS_BLK_STICKY: begin
                        st_nxt.rdata[`NUM_BLK-1:0] = st_r.blk_sticky;
                    end
                    `OFS_LOOP_STATE: begin
                        st_nxt.rdata[`NUM_LOOP*`STATE_W-1:0] = st_r.lstate;
                    end
                    default: begin
                        for (int g = 0; g < `NUM_GPIO; g++) begin
                            if (rd_hit[g]) begin
                                st_nxt.rdata[`GPIO_CFG_W-1:0] = st_r.gcfg[g];
                            end
                        end
                    end
                endcase
            end
        end

        // Data phase of a write.
        if (st_r.ph == BUS_WRITE) begin
            case (st_r.waddr)
                `OFS_CTRL: begin
                    st_nxt.glb_en = HWDATA[`CTRL_GLOBAL_EN_BIT];
                end
                `OFS_STICKY_CLR: begin
                    st_nxt.clr = HWDATA[`NUM_ALM-1:0];
                end
                `OFS_ALERT_EN: begin
                    st_nxt.alert_en = HWDATA[`NUM_ALM-1:0];
                end
                `OFS_BLK_CLR: begin
                    st_nxt.bclr = HWDATA[`NUM_BLK-1:0];
                end
                default: begin
                    st_nxt.gcfg = cfg_nxt;
                end
            endcase
        end

        // Pin outputs are registered from the per-pin levels.
        st_nxt.gout = pin_lvl;
        st_nxt.goe = pin_oe;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= '0;
            st_r.ph <= BUS_IDLE;
            st_r.glb_en <= `GLOBAL_EN_RESET;
            st_r.alert_en <= `ALERT_EN_RESET;
            st_r.gcfg <= {`NUM_GPIO{`GPIO_CFG_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign HRDATA = st_r.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign GPIO_OUT = st_r.gout;
    assign GPIO_OE = st_r.goe;

endmodule

// *** verilog/alert_hold.sv ***
// Purpose: Stretch the negation of the aggregated alert.
// Assumes: HOLD fits in HOLD_W bits.
// Notes:   Keeps the pin from chattering while sticky bits are cleared.
`timescale 1ns/1ps
`include "alarm_regs.svh"

module alert_hold #(
    parameter int unsigned HOLD = `ALERT_HOLD_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Request and stretched output.
    input wire logic req,
    output logic hold
);
    typedef struct packed {
        logic [`HOLD_W-1:0] cnt;
        logic out;
    } hold_t;

    hold_t st_r;
    hold_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (req) begin
            st_nxt.out = 1'b1;
            st_nxt.cnt = `HOLD_W'(HOLD);
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - `HOLD_W'(1);
        end else begin
            st_nxt.out = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hold = st_r.out;

endmodule

// *** verilog/sticky_bank.sv ***
// Purpose: Synchronise live alarms and keep one sticky bit per alarm.
// Assumes: Live inputs may come from any domain.
// Notes:   A change seen in the cycle of a clear leaves the bit set.
`timescale 1ns/1ps
`include "alarm_regs.svh"

module sticky_bank #(
    parameter int W = `NUM_ALM
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Alarm sources and controls.
    input wire logic [W-1:0] live_async,
    input wire logic arm,
    input wire logic [W-1:0] clr,
    // Status.
    output alarm_pkg::alarm_vec_t stat
);
    import alarm_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [W-1:0] sticky;
    } bank_t;

    bank_t st_r;
    bank_t st_nxt;
    logic [W-1:0] change;

    // The edge detector looks only at the second and third stages.
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = live_async;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
        change = st_r.sync ^ st_r.prev;
        // Set wins over clear; nothing else ever drops a sticky bit.
        st_nxt.sticky = (st_r.sticky & ~clr) |
            (change & {W{arm}});
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stat.live = st_r.sync;
    assign stat.sticky = st_r.sticky;

endmodule
